// [core/mmr_core.sv]
// Program ROM, data RAM, stack pointers, interrupt gate and pin defaults
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Reset returns pins to ports, outputs high
// - Reset makes I/O pins pulled-up inputs
// - Serial uses bits 4 to 7
// - A/D uses pins 40 to 43
// - ROM holds 8192 words of 13 bits
// - Fetch starts at 0110H after reset
// - NMI at 0100H, others 0102H to 010EH
// - RAM of 512 nibbles at 0000H-01FFH
// - 16-bit access only in 0100H-01FFH
// - Wide pointer wraps 3FFH, nibble FFH
// - Only wide stack does 16-bit access
// - Interrupts blocked until both pointers loaded
// - Reloading one pointer blocks until other
// - Call saves PC as four words
// - Interrupt saves PC and one flag word
// - Peripheral area of 73 words
module mmr_core
#(
  parameter bit PULLUP_OPT = 1'b1
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // ROM programming port
  input wire logic rom_we,
  input wire logic [12:0] rom_waddr,
  input wire logic [12:0] rom_wdata,
  // Instruction fetch
  input wire logic [15:0] fetch_addr,
  output logic [12:0] fetch_word,
  output logic cpu_start,
  output logic [15:0] start_addr,
  // Data memory port
  input wire mmr_pkg::mmr_dm_req_t dm_req,
  output logic dm_ready,
  output logic [3:0] dm_rdata,
  output logic io_sel,
  input wire logic [3:0] io_rdata,
  // Stack operations
  input wire mmr_pkg::mmr_stk_op_t stk_op,
  input wire logic [15:0] stk_pc,
  input wire logic [3:0] stk_flags,
  input wire logic sp_wide_load,
  input wire logic sp_nibble_load,
  input wire logic [9:0] sp_load_value,
  output logic stk_done,
  output logic stk_fault,
  output logic [15:0] stk_pc_out,
  output logic [3:0] stk_flags_out,
  output logic [9:0] wide_stack_pointer,
  output logic [7:0] nibble_stack_pointer,
  output logic sp_pair_ready,
  // Interrupts
  input wire logic nmi_req,
  input wire logic [6:0] irq_req,
  input wire logic irq_enable,
  output logic int_req,
  output logic [15:0] int_vector,
  // Pin function selects and peripheral signals
  input wire mmr_pkg::mmr_pin_sel_t pin_sel,
  input wire logic [11:0] r_gp_data,
  input wire logic [19:0] p_gp_data,
  input wire logic [19:0] p_gp_dir,
  input wire logic timer_output_pin,
  input wire logic clock_frequency_output,
  input wire logic serial_out_pin,
  input wire logic serial_clock_out,
  input wire logic serial_ready_pin,
  output logic serial_in_pin,
  output logic serial_clock_in,
  output logic analog_input_0,
  output logic analog_input_1,
  output logic analog_input_2,
  output logic analog_input_3,
  output logic [19:0] p_gp_in,
  // Device pins
  output logic [11:0] r_pin_out,
  input wire logic [19:0] p_pin_in,
  output logic [19:0] p_pin_out,
  output logic [19:0] p_pin_oe,
  output logic [19:0] p_pin_pullup
);

  logic [12:0] rom_mem [mmr_pkg::ROM_WORDS];
  logic [3:0] ram_mem [mmr_pkg::RAM_WORDS];
  logic [12:0] fetch_word_r;
  logic started_r;
  logic cpu_start_r;
  logic [3:0] dm_rdata_r;
  logic [9:0] spw_r;
  logic [7:0] spn_r;
  logic spw_set_r;
  logic spn_set_r;
  logic stk_done_r;
  logic stk_fault_r;
  logic [15:0] stk_pc_r;
  logic [3:0] stk_flags_r;
  logic [15:0] int_vector_r;
  mmr_pkg::mmr_pin_sel_t sel_r;
  logic [19:0] p_s1_r;
  logic [19:0] p_s2_r;
  logic [19:0] p_s3_r;
  logic [19:0] p_filt_r;
  logic [11:0] r_out_r;
  logic [19:0] p_out_r;
  logic [19:0] p_oe_r;
  logic [19:0] p_pu_r;

  // Wide stack access must lie fully inside the 16-bit capable RAM
  function automatic logic wide_ok(input logic [9:0] a);
    logic [15:0] lo;
    lo = {6'h00, a};
    wide_ok = (lo >= mmr_pkg::WIDE_FIRST) &&
              (lo + 16'h0003 <= mmr_pkg::WIDE_LAST);
  endfunction

  function automatic logic ram_hit(input logic [15:0] a);
    ram_hit = (a <= mmr_pkg::RAM_LAST);
  endfunction

  // Stack address arithmetic, shared by push and pop
  logic is_push_w;
  logic is_pop_w;
  logic is_int_w;
  logic [9:0] w_addr;
  logic [9:0] w_next;
  logic [7:0] n_addr;
  logic [7:0] n_next;
  logic w_fault;

  always_comb
  begin
    is_push_w = (stk_op == mmr_pkg::MMR_STK_CALL) ||
                (stk_op == mmr_pkg::MMR_STK_INT);
    is_pop_w = (stk_op == mmr_pkg::MMR_STK_RET) ||
               (stk_op == mmr_pkg::MMR_STK_RETI);
    is_int_w = (stk_op == mmr_pkg::MMR_STK_INT) ||
               (stk_op == mmr_pkg::MMR_STK_RETI);
    // Modular widths give the cyclic wrap for free
    w_next = is_push_w ? spw_r - mmr_pkg::PC_SAVE_WORDS
                       : spw_r + mmr_pkg::PC_SAVE_WORDS;
    w_addr = is_push_w ? w_next : spw_r;
    n_next = is_push_w ? spn_r - mmr_pkg::FLAG_SAVE_WORDS
                       : spn_r + mmr_pkg::FLAG_SAVE_WORDS;
    n_addr = is_push_w ? n_next : spn_r;
    w_fault = (is_push_w || is_pop_w) && !wide_ok(w_addr);
  end

  // Stack has the RAM this cycle; the data port waits
  assign dm_ready = (stk_op == mmr_pkg::MMR_STK_NONE);
  assign io_sel = dm_req.valid && dm_ready &&
                  (dm_req.addr >= mmr_pkg::IO_FIRST) &&
                  (dm_req.addr <= mmr_pkg::IO_LAST);

  // ROM load and fetch; unimplemented program space reads zero
  always_ff @(posedge sys_clk)
  begin
    if (rom_we)
      rom_mem[rom_waddr] <= rom_wdata;
    if (fetch_addr <= mmr_pkg::PROG_LAST)
      fetch_word_r <= rom_mem[fetch_addr[12:0]];
    else
      fetch_word_r <= 13'h0000;
  end

  // Start pulse on the first cycle after reset release
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      started_r <= 1'b0;
      cpu_start_r <= 1'b0;
    end
    else
    begin
      started_r <= 1'b1;
      cpu_start_r <= !started_r;
    end
  end

  // RAM writes: nibble port, or stack saves that are in range
  always_ff @(posedge sys_clk)
  begin
    if (dm_ready && dm_req.valid && dm_req.we && ram_hit(dm_req.addr))
      ram_mem[dm_req.addr[8:0]] <= dm_req.wdata;
    if (is_push_w && !w_fault && !sp_wide_load && !sp_nibble_load)
    begin
      for (int i = 0; i < 4; i++)
        ram_mem[9'(w_addr + 10'(i))] <= stk_pc[4*i +: 4];
      if (is_int_w)
        ram_mem[{1'b0, n_addr}] <= stk_flags;
    end
  end

  // Nibble read; unmapped data addresses read zero
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      dm_rdata_r <= 4'h0;
    else if (dm_ready && dm_req.valid && !dm_req.we)
    begin
      if (ram_hit(dm_req.addr))
        dm_rdata_r <= ram_mem[dm_req.addr[8:0]];
      else if (io_sel)
        dm_rdata_r <= io_rdata;
      else
        dm_rdata_r <= 4'h0;
    end
  end

  // Stack pointer updates; a load beats a stack operation
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      spw_r <= mmr_pkg::SPW_RESET;
      spn_r <= mmr_pkg::SPN_RESET;
    end
    else
    begin
      if (sp_wide_load)
        spw_r <= sp_load_value;
      else if ((is_push_w || is_pop_w) && !sp_nibble_load)
        spw_r <= w_next;
      if (sp_nibble_load)
        spn_r <= sp_load_value[7:0];
      else if (is_int_w && !sp_wide_load)
        spn_r <= n_next;
    end
  end

  // Pair tracking: reloading one while both set clears the other
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      spw_set_r <= 1'b0;
      spn_set_r <= 1'b0;
    end
    else if (sp_wide_load && sp_nibble_load)
    begin
      spw_set_r <= 1'b1;
      spn_set_r <= 1'b1;
    end
    else if (sp_wide_load)
    begin
      spw_set_r <= 1'b1;
      if (spw_set_r && spn_set_r)
        spn_set_r <= 1'b0;
    end
    else if (sp_nibble_load)
    begin
      spn_set_r <= 1'b1;
      if (spw_set_r && spn_set_r)
        spw_set_r <= 1'b0;
    end
  end

  // Stack results, one cycle after the operation
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      stk_done_r <= 1'b0;
      stk_fault_r <= 1'b0;
      stk_pc_r <= 16'h0000;
      stk_flags_r <= 4'h0;
    end
    else
    begin
      stk_done_r <= (is_push_w || is_pop_w) &&
                    !sp_wide_load && !sp_nibble_load;
      stk_fault_r <= w_fault && !sp_wide_load && !sp_nibble_load;
      // A dropped pop must not disturb the last popped PC; a faulting RETI still loads the flags
      if (is_pop_w && !w_fault && !sp_wide_load && !sp_nibble_load)
      begin
        for (int i = 0; i < 4; i++)
          stk_pc_r[4*i +: 4] <= ram_mem[9'(w_addr + 10'(i))];
      end
      if (stk_op == mmr_pkg::MMR_STK_RETI && !sp_wide_load &&
          !sp_nibble_load)
        stk_flags_r <= ram_mem[{1'b0, n_addr}];
    end
  end

  // Vector choice: NMI first, then lowest numbered request
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      int_vector_r <= mmr_pkg::NMI_VEC;
    else
    begin
      int_vector_r <= mmr_pkg::NMI_VEC;
      if (!nmi_req)
      begin
        for (int i = mmr_pkg::IRQ_COUNT - 1; i >= 0; i--)
          if (irq_req[i])
            int_vector_r <= mmr_pkg::IRQ_VEC_FIRST + 16'(2 * i);
      end
    end
  end

  // Even the NMI is held off until the pointer pair is valid
  assign int_req = spw_set_r && spn_set_r && started_r &&
                   (nmi_req || (irq_enable && |irq_req));

  // Select lines are captured so reset deselects them at once
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      sel_r <= '0;
    else
      sel_r <= pin_sel;
  end

  // Three-stage sync; change taken when stages two and three agree
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      p_s1_r <= 20'hFFFFF;
      p_s2_r <= 20'hFFFFF;
      p_s3_r <= 20'hFFFFF;
      p_filt_r <= 20'hFFFFF;
    end
    else
    begin
      p_s1_r <= p_pin_in;
      p_s2_r <= p_s1_r;
      p_s3_r <= p_s2_r;
      for (int i = 0; i < mmr_pkg::P_PINS; i++)
        if (p_s2_r[i] == p_s3_r[i])
          p_filt_r[i] <= p_s3_r[i];
    end
  end

  // Pin muxing; reset leaves ports high and inputs pulled up
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      r_out_r <= mmr_pkg::R_RESET;
      p_out_r <= 20'h00000;
      p_oe_r <= 20'h00000;
      p_pu_r <= PULLUP_OPT ? 20'hFFFFF : 20'h00000;
    end
    else
    begin
      r_out_r <= r_gp_data;
      if (sel_r.timer_output_pin_en)
        r_out_r[mmr_pkg::R_TIMER_OUTPUT_PIN] <= timer_output_pin;
      if (sel_r.clock_frequency_output_en)
        r_out_r[mmr_pkg::R_CLOCK_FREQUENCY_OUTPUT] <= clock_frequency_output;
      p_out_r <= p_gp_data;
      p_oe_r <= p_gp_dir;
      for (int i = 0; i < mmr_pkg::P_PINS; i++)
        p_pu_r[i] <= PULLUP_OPT && !p_gp_dir[i];
      if (sel_r.serial_en)
      begin
        p_oe_r[mmr_pkg::P_SIN] <= 1'b0;
        p_out_r[mmr_pkg::P_SERIAL_OUT_PIN] <= serial_out_pin;
        p_oe_r[mmr_pkg::P_SERIAL_OUT_PIN] <= 1'b1;
        p_out_r[mmr_pkg::P_SCLK] <= serial_clock_out;
        p_oe_r[mmr_pkg::P_SCLK] <= sel_r.serial_master;
        p_out_r[mmr_pkg::P_SERIAL_READY_PIN] <= serial_ready_pin;
        p_oe_r[mmr_pkg::P_SERIAL_READY_PIN] <= !sel_r.serial_master;
        p_pu_r[mmr_pkg::P_SERIAL_OUT_PIN] <= 1'b0;
        p_pu_r[mmr_pkg::P_SCLK] <= 1'b0;
        p_pu_r[mmr_pkg::P_SERIAL_READY_PIN] <= 1'b0;
      end
      if (sel_r.ad_en)
      begin
        // Analog inputs: no drive and no pull-up to load them
        p_oe_r[mmr_pkg::P_AD0 +: 4] <= 4'h0;
        p_pu_r[mmr_pkg::P_AD0 +: 4] <= 4'h0;
      end
    end
  end

  // Outputs
  assign fetch_word = fetch_word_r;
  assign cpu_start = cpu_start_r;
  assign start_addr = mmr_pkg::RESET_PC;
  assign dm_rdata = dm_rdata_r;
  assign stk_done = stk_done_r;
  assign stk_fault = stk_fault_r;
  assign stk_pc_out = stk_pc_r;
  assign stk_flags_out = stk_flags_r;
  assign wide_stack_pointer = spw_r;
  assign nibble_stack_pointer = spn_r;
  assign sp_pair_ready = spw_set_r && spn_set_r;
  assign int_vector = int_vector_r;
  assign serial_in_pin = sel_r.serial_en && p_filt_r[mmr_pkg::P_SIN];
  assign serial_clock_in = sel_r.serial_en && !sel_r.serial_master &&
                           p_filt_r[mmr_pkg::P_SCLK];
  assign analog_input_0 = sel_r.ad_en;
  assign analog_input_1 = sel_r.ad_en;
  assign analog_input_2 = sel_r.ad_en;
  assign analog_input_3 = sel_r.ad_en;
  assign p_gp_in = p_filt_r;
  assign r_pin_out = r_out_r;
  assign p_pin_out = p_out_r;
  assign p_pin_oe = p_oe_r;
  assign p_pin_pullup = p_pu_r;

endmodule

`default_nettype wire

// [core/mmr_pkg.sv]
// Constants and types for the memory map, stack and reset pin block
package mmr_pkg;
  // Program space
  localparam int ROM_WORDS = 8192;
  localparam int ROM_WIDTH = 13;
  localparam logic [15:0] PROG_LAST = 16'h1FFF;
  localparam logic [15:0] RESET_PC = 16'h0110;
  localparam logic [15:0] NMI_VEC = 16'h0100;
  localparam logic [15:0] IRQ_VEC_FIRST = 16'h0102;
  localparam logic [15:0] IRQ_VEC_LAST = 16'h010E;
  localparam int IRQ_COUNT = 7;
  // Data space
  localparam int RAM_WORDS = 512;
  localparam logic [15:0] RAM_LAST = 16'h01FF;
  localparam logic [15:0] WIDE_FIRST = 16'h0100;
  localparam logic [15:0] WIDE_LAST = 16'h01FF;
  localparam int IO_WORDS = 73;
  localparam logic [15:0] IO_FIRST = 16'hFF00;
  localparam logic [15:0] IO_LAST = 16'hFFFF;
  // Stack pointers
  localparam int SPW_W = 10;
  localparam int SPN_W = 8;
  localparam logic [9:0] SPW_RESET = 10'h000;
  localparam logic [7:0] SPN_RESET = 8'h00;
  localparam logic [9:0] PC_SAVE_WORDS = 10'h004;
  localparam logic [7:0] FLAG_SAVE_WORDS = 8'h01;
  // Pins
  localparam int R_PINS = 12;
  localparam int P_PINS = 20;
  localparam logic [11:0] R_RESET = 12'hFFF;
  localparam int R_TIMER_OUTPUT_PIN = 2;
  localparam int R_CLOCK_FREQUENCY_OUTPUT = 3;
  localparam int P_SIN = 4;
  localparam int P_SERIAL_OUT_PIN = 5;
  localparam int P_SCLK = 6;
  localparam int P_SERIAL_READY_PIN = 7;
  localparam int P_AD0 = 16;

  typedef enum logic [2:0]
  {
    MMR_STK_NONE = 3'b000,
    MMR_STK_CALL = 3'b001,
    MMR_STK_RET = 3'b010,
    MMR_STK_INT = 3'b011,
    MMR_STK_RETI = 3'b100
  } mmr_stk_op_t;

  typedef struct packed {
    logic timer_output_pin_en;
    logic clock_frequency_output_en;
    logic serial_en;
    logic serial_master;
    logic ad_en;
  } mmr_pin_sel_t;

  typedef struct packed {
    logic valid;
    logic we;
    logic [15:0] addr;
    logic [3:0] wdata;
  } mmr_dm_req_t;
endpackage

// [test/mmr_core_asserts.sv]
// Checker for the memory map, stack and reset pin block
`timescale 1ns/1ps
`default_nettype none
module mmr_core_asserts
#(
  parameter bit PULLUP_OPT = 1'b1
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Start and data port
  input wire logic cpu_start,
  input wire mmr_pkg::mmr_dm_req_t dm_req,
  input wire logic dm_ready,
  input wire logic io_sel,
  // Stack
  input wire mmr_pkg::mmr_stk_op_t stk_op,
  input wire logic sp_wide_load,
  input wire logic sp_nibble_load,
  input wire logic stk_done,
  input wire logic stk_fault,
  input wire logic [9:0] wide_stack_pointer,
  input wire logic [7:0] nibble_stack_pointer,
  input wire logic sp_pair_ready,
  // Interrupts
  input wire logic nmi_req,
  input wire logic int_req,
  input wire logic [15:0] int_vector,
  // Pins
  input wire logic [11:0] r_pin_out,
  input wire logic [19:0] p_pin_oe,
  input wire logic [19:0] p_pin_pullup
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  // A pointer load in the same cycle drops the stack op
  logic stk_go;
  logic call_ok;
  logic [9:0] sp_call;
  assign stk_go = !sp_wide_load && !sp_nibble_load;
  assign sp_call = wide_stack_pointer - 10'h004;
  assign call_ok = sp_call >= 10'h100 && sp_call <= 10'h1FC;

  a_ready_when_idle: assert property (
    dm_ready == (stk_op == mmr_pkg::MMR_STK_NONE))
    else $error("data port ready while stack busy");
  a_io_window: assert property (
    io_sel |-> dm_req.valid && dm_req.addr >= 16'hFF00)
    else $error("io select outside window");
  a_int_needs_pair: assert property (
    int_req |-> sp_pair_ready)
    else $error("interrupt before both pointers set");
  a_nmi_vector: assert property (
    nmi_req |=> int_vector == 16'h0100)
    else $error("wrong nmi vector");
  a_start_pulse: assert property (
    $fell(srst) |=> cpu_start ##1 !cpu_start)
    else $error("start pulse missing");
  a_pins_reset: assert property (
    $fell(srst) |-> r_pin_out == 12'hFFF && p_pin_oe == 20'h00000
      && p_pin_pullup == {20{PULLUP_OPT}})
    else $error("pins not at reset state");
  a_call_push: assert property (
    stk_op == mmr_pkg::MMR_STK_CALL && stk_go |=> stk_done
      && wide_stack_pointer == $past(wide_stack_pointer) - 10'h004)
    else $error("call push wrong");
  a_int_flag_push: assert property (
    stk_op == mmr_pkg::MMR_STK_INT && stk_go |=>
      nibble_stack_pointer == $past(nibble_stack_pointer) - 8'h01)
    else $error("flag push wrong");
  a_wide_range: assert property (
    stk_op == mmr_pkg::MMR_STK_CALL && stk_go |=> stk_fault != $past(call_ok))
    else $error("wide range check wrong");

  c_fault: cover property (stk_fault);
  c_nmi: cover property (int_req && nmi_req);
  c_io: cover property (io_sel);
endmodule

bind mmr_core mmr_core_asserts #(.PULLUP_OPT(PULLUP_OPT)) i_chk (.*);
`default_nettype wire

// [test/mmr_cpu_model.sv]
// Fetch side of the core CPU facing the block
`timescale 1ns/1ps
`default_nettype none
module mmr_cpu_model
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Start from the block
  input wire logic cpu_start,
  input wire logic [15:0] start_addr,
  // Branch from the bench
  input wire logic jump,
  input wire logic [15:0] jump_addr,
  // Fetch address
  output logic [15:0] fetch_addr
);
  // Counter folds back so plain fetches stay in program space
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      fetch_addr <= 16'h0000;
    else if (cpu_start)
      fetch_addr <= start_addr;
    else if (jump)
      fetch_addr <= jump_addr;
    else
      fetch_addr <= (fetch_addr + 16'h0001) & 16'h1FFF;
  end
endmodule
`default_nettype wire

// [test/mmr_core_tb.sv]
// Self-checking bench for the memory map, stack and reset pin block
`timescale 1ns/1ps
`default_nettype none
module mmr_core_tb;
  logic sys_clk = 1'b0, srst = 1'b1, rom_we = 1'b0, jump = 1'b0;
  logic sp_wide_load = 1'b0, sp_nibble_load = 1'b0;
  logic nmi_req = 1'b0, irq_enable = 1'b0, timer_output_pin = 1'b0;
  logic clock_frequency_output = 1'b0, serial_out_pin = 1'b0;
  logic serial_clock_out = 1'b0, serial_ready_pin = 1'b0;
  logic [12:0] rom_waddr = 13'h0000, rom_wdata = 13'h0000;
  logic [15:0] jump_addr = 16'h0000, stk_pc = 16'h0000;
  logic [3:0] stk_flags = 4'h0, io_rdata = 4'h0;
  logic [6:0] irq_req = 7'h00;
  logic [9:0] sp_load_value = 10'h000;
  logic [11:0] r_gp_data = 12'hFFF;
  logic [19:0] p_gp_data = 20'h00000, p_gp_dir = 20'h00000;
  logic [19:0] p_pin_in = 20'h00000;
  mmr_pkg::mmr_dm_req_t dm_req = '0;
  mmr_pkg::mmr_stk_op_t stk_op = mmr_pkg::MMR_STK_NONE;
  mmr_pkg::mmr_pin_sel_t pin_sel = '0;
  logic cpu_start, dm_ready, io_sel, stk_done, stk_fault, sp_pair_ready;
  logic int_req, serial_in_pin, serial_clock_in, analog_input_0;
  logic analog_input_1, analog_input_2, analog_input_3;
  logic [12:0] fetch_word;
  logic [15:0] fetch_addr, start_addr, stk_pc_out, int_vector;
  logic [3:0] dm_rdata, stk_flags_out;
  logic [9:0] wide_stack_pointer;
  logic [7:0] nibble_stack_pointer;
  logic [11:0] r_pin_out;
  logic [19:0] p_gp_in, p_pin_out, p_pin_oe, p_pin_pullup;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;

  mmr_core i_dut (.*);
  mmr_cpu_model i_cpu (.*);

  // 25 MHz clock
  initial
  begin
    forever #20 sys_clk = ~sys_clk;
  end
  // Hang guard, far above the roughly 75 cycles needed
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_mismatch++;
      stop_test;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Trailing edge keeps back-to-back loads from colliding
  task automatic sp_set(input logic wide, input logic [9:0] v);
    sp_wide_load = wide;
    sp_nibble_load = !wide;
    sp_load_value = v;
    @(negedge sys_clk);
    sp_wide_load = 1'b0;
    sp_nibble_load = 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic fetch(input logic [15:0] a, input logic [12:0] w);
    jump = 1'b1;
    jump_addr = a;
    @(negedge sys_clk);
    jump = 1'b0;
    @(negedge sys_clk);
    chk(fetch_word, w);
  endtask

  task automatic dm(input logic we, input logic [15:0] a, input logic [3:0] d);
    dm_req = '{valid: 1'b1, we: we, addr: a, wdata: d};
    #1 chk(io_sel, a >= 16'hFF00);
    @(negedge sys_clk);
    dm_req.valid = 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic stk(input mmr_pkg::mmr_stk_op_t op, input logic [15:0] pc,
    input logic [3:0] fl, input logic flt);
    stk_op = op;
    stk_pc = pc;
    stk_flags = fl;
    #1 chk(dm_ready, 1'b0);
    @(negedge sys_clk);
    stk_op = mmr_pkg::MMR_STK_NONE;
    chk({stk_done, stk_fault}, {1'b1, flt});
    @(negedge sys_clk);
  endtask

  task automatic t_reset;
    srst = 1'b0;
    @(negedge sys_clk);
    chk({cpu_start, start_addr}, {1'b1, 16'h0110});
    chk(r_pin_out, 12'hFFF);
    chk({p_pin_oe, p_pin_pullup}, {20'h00000, 20'hFFFFF});
    @(negedge sys_clk);
    chk({cpu_start, fetch_addr}, {1'b0, 16'h0110});
  endtask

  // Mid-run reset with pins driven away from their reset levels
  task automatic t_rereset;
    pin_sel = 5'h1F;
    r_gp_data = 12'h000;
    p_gp_dir = 20'hFFFFF;
    nmi_req = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk({r_pin_out, int_req}, 13'h0001);
    srst = 1'b1;
    @(negedge sys_clk);
    chk(r_pin_out, 12'hFFF);
    chk({p_pin_oe, p_pin_pullup}, {20'h00000, 20'hFFFFF});
    chk({wide_stack_pointer, nibble_stack_pointer, sp_pair_ready,
      int_req, analog_input_0}, 21'h000000);
    srst = 1'b0;
    r_gp_data = 12'hFFF;
    p_gp_dir = 20'h00000;
    pin_sel = '0;
    @(negedge sys_clk);
    chk({cpu_start, int_req}, 2'h2);
    @(negedge sys_clk);
    chk({fetch_addr, int_req}, {16'h0110, 1'b0});
    nmi_req = 1'b0;
  endtask

  // NMI held from the start: masked until the pair is complete
  task automatic t_irq;
    nmi_req = 1'b1;
    irq_enable = 1'b1;
    @(negedge sys_clk);
    chk(int_req, 1'b0);
    sp_set(1'b1, 10'h104);
    chk(int_req, 1'b0);
    sp_set(1'b0, 10'h010);
    chk({int_req, int_vector}, {1'b1, 16'h0100});
    nmi_req = 1'b0;
    irq_req = 7'h40;
    @(negedge sys_clk);
    chk({int_req, int_vector}, {1'b1, 16'h010E});
    sp_set(1'b1, 10'h104);
    chk(int_req, 1'b0);
    sp_set(1'b0, 10'h010);
    chk(int_req, 1'b1);
    irq_req = 7'h00;
  endtask

  task automatic t_mem;
    rom_we = 1'b1;
    rom_waddr = 13'h1FFF;
    rom_wdata = 13'h1A5C;
    @(negedge sys_clk);
    rom_we = 1'b0;
    fetch(16'h1FFF, 13'h1A5C);
    fetch(16'h2000, 13'h0000);
    dm(1'b1, 16'h01FF, 4'hA);
    dm(1'b0, 16'h01FF, 4'h0);
    chk(dm_rdata, 4'hA);
    dm(1'b1, 16'h0200, 4'h5);
    dm(1'b0, 16'h0200, 4'h0);
    chk(dm_rdata, 4'h0);
    io_rdata = 4'hC;
    dm(1'b0, 16'hFF00, 4'h0);
    chk(dm_rdata, 4'hC);
  endtask

  // Pushes, pops, nibble order in RAM, then both pointers wrapping
  task automatic t_stack;
    stk(mmr_pkg::MMR_STK_CALL, 16'hABCD, 4'h0, 1'b0);
    chk(wide_stack_pointer, 10'h100);
    dm(1'b0, 16'h0100, 4'h0);
    chk(dm_rdata, 4'hD);
    dm(1'b0, 16'h0103, 4'h0);
    chk(dm_rdata, 4'hA);
    stk(mmr_pkg::MMR_STK_RET, 16'h0000, 4'h0, 1'b0);
    chk({stk_pc_out, wide_stack_pointer}, {16'hABCD, 10'h104});
    stk(mmr_pkg::MMR_STK_INT, 16'h1234, 4'h9, 1'b0);
    chk({wide_stack_pointer, nibble_stack_pointer},
      {10'h100, 8'h0F});
    stk(mmr_pkg::MMR_STK_RETI, 16'h0000, 4'h0, 1'b0);
    chk({stk_pc_out, stk_flags_out}, {16'h1234, 4'h9});
    sp_set(1'b1, 10'h000);
    stk(mmr_pkg::MMR_STK_CALL, 16'h0000, 4'h0, 1'b1);
    chk(wide_stack_pointer, 10'h3FC);
    sp_set(1'b0, 10'h000);
    stk(mmr_pkg::MMR_STK_INT, 16'h0000, 4'h0, 1'b1);
    chk(nibble_stack_pointer, 8'hFF);
  endtask

  // Timer low against a high port latch shows which source drives
  task automatic t_pins;
    serial_out_pin = 1'b1;
    p_pin_in = 20'h00050;
    pin_sel = 5'h1F;
    repeat (5) @(negedge sys_clk);
    chk(r_pin_out[3:2], 2'h0);
    chk(p_gp_in, 20'h00050);
    chk({p_pin_oe[7:4], p_pin_out[5], serial_in_pin}, 6'h1B);
    chk({serial_clock_in, p_pin_pullup[7:4]}, 5'h01);
    chk({analog_input_3, analog_input_2, analog_input_1,
      analog_input_0}, 4'hF);
    chk({p_pin_oe[19:16], p_pin_pullup[19:16]}, 8'h00);
    pin_sel = 5'h04;
    repeat (2) @(negedge sys_clk);
    chk({p_pin_oe[7:4], serial_clock_in}, 5'h15);
    chk({r_pin_out[3:2], analog_input_0}, 3'h6);
    chk(p_pin_pullup[19:16], 4'hF);
  endtask

  // Main sequence
  initial
  begin
    repeat (16) @(negedge sys_clk);
    t_reset;
    t_irq;
    t_mem;
    t_stack;
    t_pins;
    t_rereset;
    stop_test;
  end
endmodule
`default_nettype wire
